// [verilog/vcc_pkg.sv]
// Constants for the VCO calibration configuration bank.
// Assumes a 25 MHz system clock and an Avalon-MM master with 32-bit data.
// Overview of operation
// - Band scale constant per variant, 1.5 to 8, is a module parameter.
// - Timing adjust bit changes calibration timing and therefore lock time.
// - Search mode code 1 is linear, code 2 mixed; 0 and 3 reserved.
// - Linear search steps through bands one by one until the band is found.
// - Mixed search halves the range first, then finishes by linear stepping.
// - Source select code 4 is manual mode; codes 0 to 3 ignore the word.
package vcc_pkg;
	localparam logic [7:0]  VCC_OFF_CLKSRC  = 8'h00;
	localparam logic [7:0]  VCC_OFF_MANWORD = 8'h04;
	localparam logic [7:0]  VCC_OFF_MODE    = 8'h08;
	localparam logic [7:0]  VCC_OFF_FIXED9  = 8'h0C;
	localparam logic [7:0]  VCC_OFF_FIXED12 = 8'h10;
	localparam logic [7:0]  VCC_OFF_CTRL    = 8'h14;
	localparam logic [7:0]  VCC_OFF_STATUS  = 8'h18;
	localparam int          VCC_MODE_ADJ_POS = 4;
	localparam logic [2:0]  VCC_SRC_MANUAL  = 3'h4;
	localparam logic [1:0]  VCC_SEARCH_LIN  = 2'h1;
	localparam logic [1:0]  VCC_SEARCH_MIX  = 2'h2;
	localparam logic [2:0]  VCC_RST_SRC     = 3'h0;
	localparam logic [11:0] VCC_RST_WORD    = 12'h000;
	localparam logic [1:0]  VCC_RST_SEARCH  = 2'h1;
	localparam logic [4:0]  VCC_BANDS       = 5'h10;
	localparam logic [3:0]  VCC_DWELL_STD   = 4'h4;
	localparam logic [3:0]  VCC_DWELL_ADJ   = 4'h8;
	localparam logic [31:0] VCC_UNMAPPED    = 32'hDEAD_0000;
	typedef enum logic [1:0] {VCC_IDLE, VCC_HALVE, VCC_STEP, VCC_DONE} vcc_st_t;
endpackage : vcc_pkg

// [verilog/vcc_top.sv]
// VCO calibration configuration bank with a small band search engine.
// Assumes a synchronous Avalon-MM master and a same-clock band comparator.
`timescale 1ns/100ps
module vcc_top import vcc_pkg::*; #(
	parameter int KSCALE_X10 = 15   // Band scale constant times ten
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic             avs_waitrequest,
	output logic [31:0]      avs_readdata,
	input  wire logic        band_high,
	output logic [3:0]       band_sel,
	output logic             cal_busy,
	output logic             cal_done
);
	// Elaboration check on the band scale range
	if (KSCALE_X10 < 15 || KSCALE_X10 > 80) begin : g_chk
		$error("band scale out of range");
	end

	logic [2:0]  src_ff;
	logic [11:0] word_ff;
	logic [1:0]  search_ff;
	logic        adj_ff;
	logic [31:0] fix9_ff;
	logic [31:0] fix12_ff;
	logic        wait_ff;
	logic [31:0] rdata_ff;
	logic [3:0]  lo_ff;
	logic [3:0]  hi_ff;
	logic [3:0]  band_ff;
	logic [3:0]  dwell_ff;
	logic        busy_ff;
	logic        done_ff;
	vcc_st_t     st_ff;
	logic        start;
	logic        acc;
	logic [3:0]  dwell_len;

	// One wait state: the access completes on the second edge
	assign acc   = (avs_read | avs_write) & ~wait_ff;
	assign start = avs_write & ~wait_ff & (avs_address == VCC_OFF_CTRL)
		& avs_writedata[0] & ~busy_ff;
	// Adjust bit stretches each dwell, giving a longer lock time
	assign dwell_len = adj_ff ? VCC_DWELL_ADJ : VCC_DWELL_STD;

	// Waitrequest idles high and drops for one cycle per request
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_ff <= 1'b1;
		end else begin
			wait_ff <= ~((avs_read | avs_write) & wait_ff);
		end
	end

	// Configuration writes; stored as written, the host owns legality
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			src_ff    <= VCC_RST_SRC;
			word_ff   <= VCC_RST_WORD;
			search_ff <= VCC_RST_SEARCH;
			adj_ff    <= 1'b0;
			fix9_ff   <= 32'h0000_0000;
			fix12_ff  <= 32'h0000_0000;
		end else if (avs_write & ~wait_ff) begin
			case (avs_address)
				VCC_OFF_CLKSRC:  src_ff <= avs_writedata[2:0];
				VCC_OFF_MANWORD: word_ff <= avs_writedata[11:0];
				VCC_OFF_MODE: begin
					search_ff <= avs_writedata[1:0];
					adj_ff    <= avs_writedata[VCC_MODE_ADJ_POS];
				end
				VCC_OFF_FIXED9:  fix9_ff <= avs_writedata;
				VCC_OFF_FIXED12: fix12_ff <= avs_writedata;
				default: ;
			endcase
		end
	end

	// Read mux; status shows engine state, current band and manual source flag
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= 32'h0000_0000;
		end else if (avs_read & wait_ff) begin
			case (avs_address)
				VCC_OFF_CLKSRC:  rdata_ff <= {29'h0, src_ff};
				VCC_OFF_MANWORD: rdata_ff <= {20'h0, word_ff};
				VCC_OFF_MODE:    rdata_ff <= {27'h0, adj_ff, 2'h0, search_ff};
				VCC_OFF_FIXED9:  rdata_ff <= fix9_ff;
				VCC_OFF_FIXED12: rdata_ff <= fix12_ff;
				VCC_OFF_CTRL:    rdata_ff <= 32'h0000_0000;
				VCC_OFF_STATUS:  rdata_ff <= {20'h0, band_ff, 5'h0,
					src_ff == VCC_SRC_MANUAL, done_ff, busy_ff};
				default:         rdata_ff <= VCC_UNMAPPED;
			endcase
		end
	end

	// Band search: linear steps, or halving then linear steps
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff    <= VCC_IDLE;
			lo_ff    <= 4'h0;
			hi_ff    <= 4'hF;
			band_ff  <= 4'h0;
			dwell_ff <= 4'h0;
			busy_ff  <= 1'b0;
			done_ff  <= 1'b0;
		end else begin
			case (st_ff)
				VCC_IDLE: if (start) begin
					busy_ff  <= 1'b1;
					done_ff  <= 1'b0;
					lo_ff    <= 4'h0;
					hi_ff    <= 4'(VCC_BANDS - 5'h1);
					dwell_ff <= dwell_len;
					band_ff  <= (search_ff == VCC_SEARCH_MIX) ? 4'h7 : 4'h0;
					st_ff    <= (search_ff == VCC_SEARCH_MIX) ? VCC_HALVE
						: VCC_STEP;
				end
				VCC_HALVE: if (dwell_ff != 4'h0) begin
					dwell_ff <= dwell_ff - 4'h1;
				end else if (hi_ff - lo_ff <= 4'h2) begin
					// Window of two or less: finish by stepping up from lo
					band_ff  <= lo_ff;
					dwell_ff <= dwell_len;
					st_ff    <= VCC_STEP;
				end else begin
					if (band_high) lo_ff <= band_ff;
					else hi_ff <= band_ff;
					band_ff  <= band_high ? 4'((5'(band_ff) + 5'(hi_ff)) >> 1)
						: 4'((5'(lo_ff) + 5'(band_ff)) >> 1);
					dwell_ff <= dwell_len;
				end
				VCC_STEP: if (dwell_ff != 4'h0) begin
					dwell_ff <= dwell_ff - 4'h1;
				end else if (!band_high || band_ff == 4'hF) begin
					// First band not below target, or the top band
					st_ff <= VCC_DONE;
				end else begin
					band_ff  <= band_ff + 4'h1;
					dwell_ff <= dwell_len;
				end
				VCC_DONE: begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
					st_ff   <= VCC_IDLE;
				end
				default: st_ff <= VCC_IDLE;
			endcase
		end
	end

	// Every output comes straight from its register
	assign avs_waitrequest = wait_ff;
	assign avs_readdata    = rdata_ff;
	assign band_sel        = band_ff;
	assign cal_busy        = busy_ff;
	assign cal_done        = done_ff;

	// Band search checks: entry, stepping, halving, stopping and dwell
	AST_LIN_STEP: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		st_ff == VCC_STEP && $past(st_ff) == VCC_STEP
		&& band_ff != $past(band_ff)
		|-> band_ff == $past(band_ff) + 4'h1) else $error("linear skip");
	AST_LIN_ENTRY: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		start && search_ff != VCC_SEARCH_MIX
		|=> st_ff == VCC_STEP && band_ff == 4'h0) else $error("linear entry");
	AST_STEP_STOP: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		st_ff == VCC_STEP && dwell_ff == 4'h0 && !band_high
		|=> st_ff == VCC_DONE) else $error("step stop");
	AST_MIX_ENTRY: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		start && search_ff == VCC_SEARCH_MIX
		|=> st_ff == VCC_HALVE) else $error("mixed entry");
	// Each halving decision must shrink the window, or the search stalls
	AST_HALVE_NARROW: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		st_ff == VCC_HALVE && dwell_ff == 4'h0 && hi_ff - lo_ff > 4'h2
		|=> hi_ff - lo_ff < $past(hi_ff - lo_ff)) else $error("halving");
	AST_DWELL: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		start |=> dwell_ff == $past(dwell_len)) else $error("dwell");
	AST_DONE_FLAG: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		st_ff == VCC_DONE |=> done_ff && !busy_ff && st_ff == VCC_IDLE)
		else $error("done flag");
	AST_START_BUSY: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		start |=> busy_ff && !done_ff) else $error("start busy");

	// Register stores land on the completing edge only
	AST_MODE_STORE: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		avs_write && !wait_ff && avs_address == VCC_OFF_MODE
		|=> search_ff == $past(avs_writedata[1:0])) else $error("mode");
	AST_WORD: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		avs_write && !wait_ff && avs_address == VCC_OFF_MANWORD
		|=> word_ff == $past(avs_writedata[11:0])) else $error("word");
	AST_FIX9: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		avs_write && !wait_ff && avs_address == VCC_OFF_FIXED9
		|=> fix9_ff == $past(avs_writedata)) else $error("fixed9");
	AST_FIX12: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		avs_write && !wait_ff && avs_address == VCC_OFF_FIXED12
		|=> fix12_ff == $past(avs_writedata)) else $error("fixed12");
	AST_WAIT: assert property (@(posedge sys_clk)
		disable iff (!rst_n)
		acc |=> wait_ff) else $error("wait");

	// Main scenarios: both methods, adjusted timing, search at band zero
	COV_LIN: cover property (@(posedge sys_clk) disable iff (!rst_n)
		st_ff == VCC_STEP ##1 st_ff == VCC_DONE);
	COV_MIX: cover property (@(posedge sys_clk) disable iff (!rst_n)
		st_ff == VCC_HALVE ##1 st_ff == VCC_STEP);
	COV_ADJ: cover property (@(posedge sys_clk) disable iff (!rst_n)
		start && adj_ff);
	COV_LOW: cover property (@(posedge sys_clk) disable iff (!rst_n)
		st_ff == VCC_DONE && band_ff == 4'h0);
endmodule : vcc_top

// [tb/vcc_band_model.sv]
// Band comparator model standing beside the search engine.
// Assumes the bench sets the target band before each search.
`timescale 1ns/100ps
module vcc_band_model (
	input  wire logic [3:0] band_sel,
	input  wire logic [3:0] target,
	output logic            band_high
);
	// Plain level compare, the same way the real comparator answers
	assign band_high = band_sel < target;
endmodule : vcc_band_model

// [tb/tb_top.sv]
// Bench for the calibration bank: registers, band search and timing.
// Assumes the band model as far side and a 25 MHz clock.
`timescale 1ns/100ps
module tb_top;
	import vcc_pkg::*;
	logic        sys_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic        avs_waitrequest;
	logic [31:0] avs_readdata;
	logic        band_high;
	logic [3:0]  band_sel;
	logic        cal_busy;
	logic        cal_done;
	logic [3:0]  target = 4'h0;
	logic [31:0] exp_q[$];
	logic [31:0] w;
	int          failures = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          n_std;
	int          n;
	vcc_top #(.KSCALE_X10(15)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
		.band_high(band_high), .band_sel(band_sel),
		.cal_busy(cal_busy), .cal_done(cal_done));
	vcc_band_model u_band (.band_sel(band_sel), .target(target),
		.band_high(band_high));
	// Free-running clock
	always #20 sys_clk = ~sys_clk;
	task automatic end_sim();
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			end_sim();
		end
	end
	// Read results are matched against notes in issue order
	always @(posedge sys_clk)
		if (avs_read && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
			samples_checked++;
			if (avs_readdata !== exp_q[0]) begin
				failures++;
				$display("wrong value at %0t: read %h", $time, avs_readdata);
			end
			void'(exp_q.pop_front());
		end
	// Request held until waitrequest low; spare edge avoids re-driving
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= ~wr;
		avs_write <= wr;
		@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0)
			@(posedge sys_clk);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd
	// Run one search and check the band it settles on
	task automatic srch(input logic [3:0] t, input logic [1:0] m,
		input logic adj, input logic man);
		target <= t;
		bus(1'b1, VCC_OFF_MODE, {27'h0, adj, 2'h0, m});
		bus(1'b1, VCC_OFF_CTRL, 32'h1);
		n = 0;
		while (cal_done !== 1'b1) begin
			@(posedge sys_clk);
			n++;
		end
		samples_checked++;
		if (band_sel !== t || cal_busy !== 1'b0) begin
			failures++;
			$display("wrong value at %0t: band %h", $time, band_sel);
		end
		rd(VCC_OFF_STATUS, {20'h0, t, 5'h0, man, 2'h2});
	endtask : srch
	initial begin
		void'($urandom(39));
		repeat (8) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		// Reset contents and an unmapped hole
		bus(1'b1, 8'hFC, 32'hFFFF_FFFF);
		rd(VCC_OFF_CLKSRC, 32'h0);
		rd(VCC_OFF_MANWORD, 32'h0);
		rd(VCC_OFF_MODE, 32'h1);
		rd(8'hFC, VCC_UNMAPPED);
		// Manual mode, a random word, then the widest word
		w = {20'h0, 12'($urandom_range(4095))};
		bus(1'b1, VCC_OFF_CLKSRC, 32'h4);
		bus(1'b1, VCC_OFF_MANWORD, w);
		rd(VCC_OFF_MANWORD, w);
		bus(1'b1, VCC_OFF_MANWORD, 32'hFFFF_FFFF);
		rd(VCC_OFF_MANWORD, 32'h0000_0FFF);
		// Fixed-content registers keep what the host loads
		w = $urandom();
		bus(1'b1, VCC_OFF_FIXED9, w);
		rd(VCC_OFF_FIXED9, w);
		bus(1'b1, VCC_OFF_FIXED12, ~w);
		rd(VCC_OFF_FIXED12, ~w);
		// Every search code, reserved ones stored as written
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, VCC_OFF_MODE, 32'(c));
			rd(VCC_OFF_MODE, 32'(c));
		end
		// Both methods, band limits, and the slower adjusted timing
		srch(4'($urandom_range(15)), VCC_SEARCH_LIN, 1'b0, 1'b1);
		srch(4'hF, VCC_SEARCH_LIN, 1'b0, 1'b1);
		n_std = n;
		srch(4'hF, VCC_SEARCH_LIN, 1'b1, 1'b1);
		samples_checked++;
		if (n <= n_std) begin
			failures++;
			$display("wrong value at %0t: adjusted search not slower", $time);
		end
		for (int t = 0; t < 16; t += 5)
			srch(4'(t), VCC_SEARCH_MIX, 1'b0, 1'b1);
		bus(1'b1, VCC_OFF_CLKSRC, 32'h0);
		srch(4'h0, VCC_SEARCH_LIN, 1'b0, 1'b0);
		end_sim();
	end
endmodule : tb_top
